// ### adf_pkg.sv
// Shared constants and carrier types for the converter's digital feature
// control register bank.
// Assumes an 8-bit register port with 13-bit addresses from a serial
// port front end that runs on the same clock as this bank.
package adf_pkg;

  // Register port geometry.
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int NUM_CH = 2;

  // Register offsets.
  localparam logic [12:0] A_OR_PIN    = 13'h002A;
  localparam logic [12:0] A_OUT_ASSGN = 13'h002E;
  localparam logic [12:0] A_SYNC      = 13'h0100;
  localparam logic [12:0] A_USER2     = 13'h0101;
  localparam logic [12:0] A_IQ_CTRL   = 13'h0110;
  localparam logic [12:0] A_IQ_FORCE  = 13'h0111;
  localparam logic [12:0] A_GAIN_BW   = 13'h0112;
  localparam logic [12:0] A_PHASE_BW  = 13'h0113;
  localparam logic [12:0] A_DC_BW     = 13'h0114;
  localparam logic [12:0] A_GAIN_LO   = 13'h0116;
  localparam logic [12:0] A_GAIN_HI   = 13'h0117;
  localparam logic [12:0] A_PHASE_LO  = 13'h0118;
  localparam logic [12:0] A_PHASE_HI  = 13'h0119;
  localparam logic [12:0] A_DCI_LO    = 13'h011A;
  localparam logic [12:0] A_DCI_HI    = 13'h011B;
  localparam logic [12:0] A_DCQ_LO    = 13'h011C;
  localparam logic [12:0] A_DCQ_HI    = 13'h011D;

  // Reset values.
  localparam logic [7:0] RST_SYNC  = 8'h01;
  localparam logic [7:0] RST_USER2 = 8'h88;
  localparam logic [7:0] RST_ZERO  = 8'h00;
  localparam logic [4:0] RST_EXP   = 5'h02;
  // Per-channel resets: overrange pin on for both, A routed A, B routed B.
  localparam logic [1:0] RST_OR_EN  = 2'h3;
  localparam logic [1:0] RST_ASSIGN = 2'h2;

  // Writable bit masks; open bits are dropped on write.
  localparam logic [7:0] MSK_SYNC  = 8'h07;
  localparam logic [7:0] MSK_USER2 = 8'h8D;
  localparam logic [7:0] MSK_CTRL  = 8'h3F;
  localparam logic [7:0] MSK_FORCE = 8'h07;

  // Field positions.
  localparam int B_MASTER  = 0;
  localparam int B_DIV_EN  = 1;
  localparam int B_NEXT    = 2;
  localparam int B_PD_DIS  = 0;
  localparam int B_RUN_OSC = 2;
  localparam int B_DETECT  = 3;
  localparam int B_OE_FUNC = 7;
  localparam int B_FREEZE  = 3;

  // Widths of the initial correction values.
  localparam int W_GAIN  = 15;
  localparam int W_PHASE = 13;
  localparam int W_DC    = 14;

  // Divider sync mode, Gray coded along off, continuous, one-shot.
  typedef enum logic [1:0] {
    SYNC_OFF  = 2'b00,
    SYNC_CONT = 2'b01,
    SYNC_ONCE = 2'b11
  } adf_sync_mode_t;

  // Correction settings; term bit 0 gain, 1 phase, 2 dc.
  typedef struct packed {
    logic [2:0]         enable;
    logic [2:0]         freeze;
    logic [2:0]         forceOn;
    logic [2:0]         estimate;
    logic [4:0]         gainExp;
    logic [4:0]         phaseExp;
    logic [4:0]         dcExp;
    logic [W_GAIN-1:0]  initGain;
    logic [W_PHASE-1:0] initPhase;
    logic [W_DC-1:0]    initDcI;
    logic [W_DC-1:0]    initDcQ;
  } adf_iq_cfg_t;

  // Clock, oscillator and pin controls.
  typedef struct packed {
    logic divSyncPulse;
    logic oscRun;
    logic outputsOff;
    logic pullDownOn;
  } adf_misc_t;

endpackage : adf_pkg

// ### adf_feature_regs.sv
// Digital feature control register bank of a dual converter: divider
// sync gating, user control, iq mismatch correction settings and the
// per-channel overrange pin and output assignment.
// Assumes a serial port front end on clk that presents one byte access
// at a time, and a channel index that selects the local registers.
//
// Operation
// - No sync action without master sync enable.
// - Pulses reach divider only with both enables.
// - Next-only clear means resync every pulse.
// - One-shot mode takes first pulse, ignores rest.
// - One-shot sync clears divider enable bit itself.
// - Function bit makes output enable pin effective.
// - Detect bit starts oscillator on low rate.
// - Detect bit clear disables the low-rate detector.
// - Run bit forces the oscillator on, overriding detector.
// - Bit zero set switches serial pull-down off.
// - Freeze bits halt estimation, keep last value.
// - Enable bits switch each correction term; default off.
// - Force dc applies initial dc I and Q.
// - Force phase applies initial phase value.
// - Force gain applies initial gain value.
// - Gain loop exponent, five bits, default two.
// - Phase loop exponent, five bits, default two.
// - Dc loop exponent, five bits, default two.
// - Initial values split into low, high bytes.
`timescale 1ns/1ps

module adf_feature_regs (
  // Clock and reset.
  input  wire  logic                      clk,
  input  wire  logic                      rstn,
  // Register port from the serial front end.
  input  wire  logic                      regWrEn,
  input  wire  logic                      regRdEn,
  input  wire  logic [adf_pkg::ADDR_W-1:0] regAddr,
  input  wire  logic [adf_pkg::DATA_W-1:0] regWrData,
  output logic       [adf_pkg::DATA_W-1:0] regRdData,
  output logic                            regRdValid,
  // Channel index for the local registers, bit 0 A, bit 1 B.
  input  wire  logic [adf_pkg::NUM_CH-1:0] chanSelect,
  // Asynchronous inputs from pins and analog circuits.
  input  wire  logic                      syncPin,
  input  wire  logic                      outEnPin,
  input  wire  logic                      encodeRateLow,
  // Controls to the rest of the converter.
  output adf_pkg::adf_misc_t               miscCtrl,
  output adf_pkg::adf_iq_cfg_t             iqCfg,
  output logic       [adf_pkg::NUM_CH-1:0] orPinEnable,
  output logic       [adf_pkg::NUM_CH-1:0] chanAssign
);

  // Global registers.
  logic [7:0] syncCtrl_r;          // Sync control.
  logic [7:0] user2_r;             // User control two.
  logic [7:0] iqCtrl_r;            // Enables and freezes.
  logic [7:0] iqForce_r;           // Force bits.
  logic [4:0] gainExp_r;           // Gain loop exponent.
  logic [4:0] phaseExp_r;          // Phase loop exponent.
  logic [4:0] dcExp_r;             // Dc loop exponent.
  logic [7:0] gainLo_r;            // Initial gain, low byte.
  logic [6:0] gainHi_r;            // Initial gain, high bits.
  logic [7:0] phaseLo_r;           // Initial phase, low byte.
  logic [4:0] phaseHi_r;           // Initial phase, high bits.
  logic [7:0] dcILo_r;             // Initial dc I, low byte.
  logic [5:0] dcIHi_r;             // Initial dc I, high bits.
  logic [7:0] dcQLo_r;             // Initial dc Q, low byte.
  logic [5:0] dcQHi_r;             // Initial dc Q, high bits.

  // Per-channel local registers.
  logic [adf_pkg::NUM_CH-1:0] orEn_r;      // Overrange pin enables.
  logic [adf_pkg::NUM_CH-1:0] assign_r;    // Output assignment.

  // Synchronisers and sync edge detection.
  logic [1:0] syncPinFf_r;         // Sync pin, two flops.
  logic       syncPrev_r;          // Previous synchronised level.
  logic [1:0] oePinFf_r;           // Output enable pin, two flops.
  logic [1:0] rateLowFf_r;         // Low rate flag, two flops.
  logic       syncEdge;            // Rising edge on the sync pin.

  // Sync mode and the one-shot self clear.
  adf_pkg::adf_sync_mode_t syncMode;
  logic       divEnClear;          // One-shot pulse consumed.

  // Write strobe per address.
  // Reads decode the address in their own case.
  function automatic logic wrHit(input logic [12:0] a);
    wrHit = regWrEn && (regAddr == a);
  endfunction : wrHit

  // Double flop every asynchronous input before any logic looks at it.
  // The first stage may be metastable, so only the shift reads it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // Idle low levels, so no false edge follows release.
      syncPinFf_r <= 2'h0;
      oePinFf_r   <= 2'h0;
      rateLowFf_r <= 2'h0;
      syncPrev_r  <= 1'b0;
    end else begin
      // One stage per clock for every pin.
      syncPinFf_r <= {syncPinFf_r[0], syncPin};
      oePinFf_r   <= {oePinFf_r[0], outEnPin};
      rateLowFf_r <= {rateLowFf_r[0], encodeRateLow};
      syncPrev_r  <= syncPinFf_r[1];
    end
  end

  // Only the second flop feeds the edge detector.
  // Pin pulses shorter than one clock may be missed.
  assign syncEdge = syncPinFf_r[1] & ~syncPrev_r;

  // Pick the divider sync mode from the three control bits.
  // The mode is combinational; consumers register what they need.
  always_comb begin
    case ({syncCtrl_r[adf_pkg::B_MASTER], syncCtrl_r[adf_pkg::B_DIV_EN]})
      2'b11: begin
        if (syncCtrl_r[adf_pkg::B_NEXT]) begin
          syncMode = adf_pkg::SYNC_ONCE;
        end else begin
          syncMode = adf_pkg::SYNC_CONT;
        end
      end
      // Master off, or divider gate closed: no sync at all.
      default: begin
        syncMode = adf_pkg::SYNC_OFF;
      end
    endcase
  end

  // In one-shot mode the first pulse disarms the divider gate.
  assign divEnClear = syncEdge && (syncMode == adf_pkg::SYNC_ONCE);

  // Sync control; a software write in the clearing cycle wins, because
  // it is a fresh arm that the host expects to take effect.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      syncCtrl_r <= adf_pkg::RST_SYNC;
    end else if (wrHit(adf_pkg::A_SYNC)) begin
      syncCtrl_r <= regWrData & adf_pkg::MSK_SYNC;
    end else if (divEnClear) begin
      // Only the divider gate drops; the other bits stay.
      syncCtrl_r[adf_pkg::B_DIV_EN] <= 1'b0;
    end
  end

  // User control two.
  // Reset leaves the pin function and rate detector on.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      user2_r <= adf_pkg::RST_USER2;
    end else if (wrHit(adf_pkg::A_USER2)) begin
      user2_r <= regWrData & adf_pkg::MSK_USER2;
    end
  end

  // Correction control and force registers.
  // Freeze bits act only on terms that are enabled.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      iqCtrl_r  <= adf_pkg::RST_ZERO;
      iqForce_r <= adf_pkg::RST_ZERO;
    end else begin
      if (wrHit(adf_pkg::A_IQ_CTRL)) begin
        iqCtrl_r <= regWrData & adf_pkg::MSK_CTRL;
      end
      // Force bits select the static values over the estimates.
      if (wrHit(adf_pkg::A_IQ_FORCE)) begin
        iqForce_r <= regWrData & adf_pkg::MSK_FORCE;
      end
    end
  end

  // Loop exponents; the upper three bits are open and never stored.
  // The loops decode the time constant; this bank only stores it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gainExp_r  <= adf_pkg::RST_EXP;
      phaseExp_r <= adf_pkg::RST_EXP;
      dcExp_r    <= adf_pkg::RST_EXP;
    end else begin
      // Each write keeps the five exponent bits only.
      if (wrHit(adf_pkg::A_GAIN_BW)) begin
        gainExp_r <= regWrData[4:0];
      end
      if (wrHit(adf_pkg::A_PHASE_BW)) begin
        phaseExp_r <= regWrData[4:0];
      end
      if (wrHit(adf_pkg::A_DC_BW)) begin
        dcExp_r <= regWrData[4:0];
      end
    end
  end

  // Initial values, each byte written on its own; the halves are not
  // staged, so a consumer may see a mixed value between the two writes.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gainLo_r  <= 8'h00;
      gainHi_r  <= 7'h00;
      phaseLo_r <= 8'h00;
      phaseHi_r <= 5'h00;
      dcILo_r   <= 8'h00;
      dcIHi_r   <= 6'h00;
      dcQLo_r   <= 8'h00;
      dcQHi_r   <= 6'h00;
    end else begin
      // Low bytes hold bits 7 to 0; high bytes the rest.
      if (wrHit(adf_pkg::A_GAIN_LO)) begin
        gainLo_r <= regWrData;
      end
      if (wrHit(adf_pkg::A_GAIN_HI)) begin
        gainHi_r <= regWrData[6:0];
      end
      if (wrHit(adf_pkg::A_PHASE_LO)) begin
        phaseLo_r <= regWrData;
      end
      if (wrHit(adf_pkg::A_PHASE_HI)) begin
        phaseHi_r <= regWrData[4:0];
      end
      if (wrHit(adf_pkg::A_DCI_LO)) begin
        dcILo_r <= regWrData;
      end
      if (wrHit(adf_pkg::A_DCI_HI)) begin
        dcIHi_r <= regWrData[5:0];
      end
      if (wrHit(adf_pkg::A_DCQ_LO)) begin
        dcQLo_r <= regWrData;
      end
      if (wrHit(adf_pkg::A_DCQ_HI)) begin
        dcQHi_r <= regWrData[5:0];
      end
    end
  end

  // Local registers: a write lands in every channel the index selects.
  // Both index bits set: one write reaches both channels.
  genvar ch;
  generate
    for (ch = 0; ch < adf_pkg::NUM_CH; ch++) begin : g_chan
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          orEn_r[ch]   <= adf_pkg::RST_OR_EN[ch];
          assign_r[ch] <= adf_pkg::RST_ASSIGN[ch];
        end else if (chanSelect[ch]) begin
          // Unselected channels keep their setting.
          if (wrHit(adf_pkg::A_OR_PIN)) begin
            orEn_r[ch] <= regWrData[0];
          end
          if (wrHit(adf_pkg::A_OUT_ASSGN)) begin
            assign_r[ch] <= regWrData[0];
          end
        end
      end
    end
  endgenerate

  // Read data one cycle after the strobe; local registers answer for
  // channel A when it is selected, otherwise for B.
  // A same-cycle write to the address is not yet visible.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdData  <= 8'h00;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
      if (regRdEn) begin
        case (regAddr)
          adf_pkg::A_OR_PIN:
            regRdData <= {7'h00, chanSelect[0] ? orEn_r[0] : orEn_r[1]};
          adf_pkg::A_OUT_ASSGN:
            regRdData <= {7'h00, chanSelect[0] ? assign_r[0] : assign_r[1]};
          // Global registers; open bits were never stored.
          adf_pkg::A_SYNC:     regRdData <= syncCtrl_r;
          adf_pkg::A_USER2:    regRdData <= user2_r;
          adf_pkg::A_IQ_CTRL:  regRdData <= iqCtrl_r;
          adf_pkg::A_IQ_FORCE: regRdData <= iqForce_r;
          adf_pkg::A_GAIN_BW:  regRdData <= {3'h0, gainExp_r};
          adf_pkg::A_PHASE_BW: regRdData <= {3'h0, phaseExp_r};
          adf_pkg::A_DC_BW:    regRdData <= {3'h0, dcExp_r};
          adf_pkg::A_GAIN_LO:  regRdData <= gainLo_r;
          adf_pkg::A_GAIN_HI:  regRdData <= {1'h0, gainHi_r};
          adf_pkg::A_PHASE_LO: regRdData <= phaseLo_r;
          adf_pkg::A_PHASE_HI: regRdData <= {3'h0, phaseHi_r};
          adf_pkg::A_DCI_LO:   regRdData <= dcILo_r;
          adf_pkg::A_DCI_HI:   regRdData <= {2'h0, dcIHi_r};
          adf_pkg::A_DCQ_LO:   regRdData <= dcQLo_r;
          adf_pkg::A_DCQ_HI:   regRdData <= {2'h0, dcQHi_r};
          // Unmapped addresses read as zero.
          default:             regRdData <= 8'h00;
        endcase
      end
    end
  end

  // Clock, oscillator and pin controls, registered.
  // Registering them keeps decode glitches off the analog side.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // All controls inactive while in reset.
      miscCtrl <= '0;
    end else begin
      // Divider sees a pulse only while a sync mode is live.
      miscCtrl.divSyncPulse <= syncEdge &&
                               (syncMode != adf_pkg::SYNC_OFF);
      // Run bit overrides; detector only counts while enabled.
      miscCtrl.oscRun <= user2_r[adf_pkg::B_RUN_OSC] |
                         (user2_r[adf_pkg::B_DETECT] &
                          rateLowFf_r[1]);
      // Pin high turns outputs off only when its function is enabled.
      miscCtrl.outputsOff <= user2_r[adf_pkg::B_OE_FUNC] &
                             oePinFf_r[1];
      miscCtrl.pullDownOn <= ~user2_r[adf_pkg::B_PD_DIS];
    end
  end

  // Correction settings to the datapath, registered.
  // Each field follows its register by one cycle, two cycles after the write strobe.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // Settings read zero until the first edge after release.
      iqCfg <= '0;
    end else begin
      iqCfg.enable   <= iqCtrl_r[2:0];
      iqCfg.freeze   <= iqCtrl_r[adf_pkg::B_FREEZE +: 3];
      // Estimation runs only for enabled, unfrozen terms.
      iqCfg.estimate <= iqCtrl_r[2:0] &
                        ~iqCtrl_r[adf_pkg::B_FREEZE +: 3];
      iqCfg.forceOn  <= iqForce_r[2:0];
      iqCfg.gainExp  <= gainExp_r;
      iqCfg.phaseExp <= phaseExp_r;
      iqCfg.dcExp    <= dcExp_r;
      iqCfg.initGain  <= {gainHi_r, gainLo_r};
      iqCfg.initPhase <= {phaseHi_r, phaseLo_r};
      iqCfg.initDcI   <= {dcIHi_r, dcILo_r};
      iqCfg.initDcQ   <= {dcQHi_r, dcQLo_r};
    end
  end

  // Per-channel pin controls come straight from their flops.
  // The pin drivers sit outside; these are enables only.
  assign orPinEnable = orEn_r;
  assign chanAssign  = assign_r;

endmodule : adf_feature_regs

// ### adf_feature_regs_checker.sv
// Port level checks of the feature control register bank.
// Assumes one clock domain and the latencies of the bank's register port.
`timescale 1ns/1ps

module adf_feature_regs_checker (
  // Clock and reset.
  input wire logic                         clk,
  input wire logic                         rstn,
  // Register port.
  input wire logic                         regWrEn,
  input wire logic                         regRdEn,
  input wire logic [adf_pkg::ADDR_W-1:0]   regAddr,
  input wire logic [adf_pkg::DATA_W-1:0]   regWrData,
  input wire logic [adf_pkg::DATA_W-1:0]   regRdData,
  input wire logic                         regRdValid,
  // Pins and controls.
  input wire logic [adf_pkg::NUM_CH-1:0]   chanSelect,
  input wire logic                         syncPin,
  input wire logic                         outEnPin,
  input wire logic                         encodeRateLow,
  input wire adf_pkg::adf_misc_t           miscCtrl,
  input wire adf_pkg::adf_iq_cfg_t         iqCfg,
  input wire logic [adf_pkg::NUM_CH-1:0]   orPinEnable,
  input wire logic [adf_pkg::NUM_CH-1:0]   chanAssign
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // A byte write to one address, and a byte read from one address.
  sequence s_wr(logic [12:0] a);
    regWrEn && (regAddr == a);
  endsequence
  sequence s_rd(logic [12:0] a);
    regRdEn && (regAddr == a);
  endsequence

  // Every read is answered exactly one cycle later, and only then.
  a_read_valid: assert property (regRdEn |=> regRdValid)
    else $error("read not answered after one cycle");
  a_valid_pulse: assert property (!regRdEn |=> !regRdValid)
    else $error("read valid without a read");
  // Open bits of the sync control register always read as zero.
  a_open_sync: assert property (s_rd(adf_pkg::A_SYNC) |=>
    regRdData[7:3] == 5'h00) else $error("open sync bits not zero");
  // The loop exponent written reaches the correction settings.
  a_gain_exp: assert property (s_wr(adf_pkg::A_GAIN_BW) |=>
    ##1 iqCfg.gainExp == $past(regWrData[4:0], 2))
    else $error("gain exponent not applied");
  a_dc_exp: assert property (s_wr(adf_pkg::A_DC_BW) |=>
    ##1 iqCfg.dcExp == $past(regWrData[4:0], 2))
    else $error("dc exponent not applied");
  // The high byte of the initial gain fills bits 14 to 8.
  a_gain_high: assert property (s_wr(adf_pkg::A_GAIN_HI) |=>
    ##1 iqCfg.initGain[14:8] == $past(regWrData[6:0], 2))
    else $error("initial gain high byte misplaced");
  // Bit zero of the user control register switches the pull-down off.
  a_pull_down: assert property (s_wr(adf_pkg::A_USER2) |=>
    ##1 miscCtrl.pullDownOn == !$past(regWrData[0], 2))
    else $error("pull-down does not follow its bit");
  // Estimation runs only for enabled terms that are not frozen.
  a_estimate_mix: assert property (iqCfg.estimate ==
    (iqCfg.enable & ~iqCfg.freeze)) else $error("estimate mix wrong");
  // A divider pulse needs a recent high level on the sync pin.
  a_sync_cause: assert property (miscCtrl.divSyncPulse |->
    $past(syncPin, 3) || $past(syncPin, 4) || $past(syncPin, 5))
    else $error("divider pulse without a sync edge");
  a_sync_single: assert property (miscCtrl.divSyncPulse |=>
    !miscCtrl.divSyncPulse) else $error("divider pulse too long");
  // Writing channel A leaves channel B's overrange enable alone.
  a_chan_local: assert property (
    regWrEn && regAddr == adf_pkg::A_OR_PIN && chanSelect == 2'b01
    |=> $stable(orPinEnable[1]) [*2])
    else $error("unselected channel changed");
  // Outputs are switched off only while the pin asks for it.
  a_outputs_off: assert property (miscCtrl.outputsOff |->
    $past(outEnPin, 2) || $past(outEnPin, 3) || $past(outEnPin, 4))
    else $error("outputs off without the pin");
endmodule : adf_feature_regs_checker

bind adf_feature_regs adf_feature_regs_checker u_chk (
  .clk(clk), .rstn(rstn), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
  .regRdValid(regRdValid), .chanSelect(chanSelect), .syncPin(syncPin),
  .outEnPin(outEnPin), .encodeRateLow(encodeRateLow),
  .miscCtrl(miscCtrl), .iqCfg(iqCfg), .orPinEnable(orPinEnable),
  .chanAssign(chanAssign));

// ### adf_reg_host.sv
// Model of the serial front end that configures the register bank.
// Assumes the bank takes a strobe on the rising edge of clk.
`timescale 1ns/1ps

module adf_reg_host (
  // Clock.
  input wire logic                         clk,
  // Register port towards the bank.
  output logic                             regWrEn,
  output logic                             regRdEn,
  output logic [adf_pkg::ADDR_W-1:0]       regAddr,
  output logic [adf_pkg::DATA_W-1:0]       regWrData,
  input wire logic [adf_pkg::DATA_W-1:0]   regRdData,
  input wire logic                         regRdValid
);
  // Idle port at time zero.
  initial begin
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
    regAddr   = 13'h0000;
    regWrData = 8'h00;
  end

  // One byte write; released lines show the inverse so stale values
  // never look valid.
  task wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 regWrEn = 1'b1;
    regAddr   = a;
    regWrData = d;
    @(posedge clk);
    #1 regWrEn = 1'b0;
    regAddr   = ~a;
    regWrData = ~d;
  endtask : wr

  // One byte read; the answer is taken once the taking edge has landed.
  task rd(input logic [12:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    #1 regRdEn = 1'b1;
    regAddr = a;
    @(posedge clk);
    #1 d = regRdData;
    v = regRdValid;
    regRdEn = 1'b0;
    regAddr = ~a;
  endtask : rd
endmodule : adf_reg_host

// ### adf_feature_regs_tb.sv
// Self-checking bench of the feature control register bank.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ps

module adf_feature_regs_tb;
  logic                       clk, rstn, regWrEn, regRdEn, regRdValid;
  logic [adf_pkg::ADDR_W-1:0] regAddr;
  logic [adf_pkg::DATA_W-1:0] regWrData, regRdData;
  logic [adf_pkg::NUM_CH-1:0] chanSelect, orPinEnable, chanAssign;
  logic                       syncPin, outEnPin, encodeRateLow;
  adf_pkg::adf_misc_t         miscCtrl;
  adf_pkg::adf_iq_cfg_t       iqCfg;
  int                         failCount, cmpCount, syncCount;
  // Address table with reset values and the bits that keep a write.
  logic [12:0] al [17] = '{adf_pkg::A_OR_PIN, adf_pkg::A_SYNC,
    adf_pkg::A_USER2, adf_pkg::A_IQ_CTRL, adf_pkg::A_IQ_FORCE,
    adf_pkg::A_GAIN_BW, adf_pkg::A_PHASE_BW, adf_pkg::A_DC_BW,
    adf_pkg::A_GAIN_LO, adf_pkg::A_GAIN_HI, adf_pkg::A_PHASE_LO,
    adf_pkg::A_PHASE_HI, adf_pkg::A_DCI_LO, adf_pkg::A_DCI_HI,
    adf_pkg::A_DCQ_LO, adf_pkg::A_DCQ_HI, 13'h0115};
  logic [7:0] rv [17] = '{8'h01, 8'h01, 8'h88, 8'h00, 8'h00, 8'h02,
    8'h02, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00};
  logic [7:0] mk [17] = '{8'h01, 8'h07, 8'h8D, 8'h3F, 8'h07, 8'h1F,
    8'h1F, 8'h1F, 8'hFF, 8'h7F, 8'hFF, 8'h1F, 8'hFF, 8'h3F, 8'hFF,
    8'h3F, 8'h00};
  // User control values, rate flag and expected {osc, off, pull-down}.
  logic [7:0] uw [6] = '{8'h01, 8'h08, 8'h04, 8'h80, 8'h00, 8'h08};
  logic       rl [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [2:0] ue [6] = '{3'h0, 3'h5, 3'h5, 3'h3, 3'h1, 3'h1};
  // Sync control values, pin edges, divider pulses and readback.
  logic [7:0] sw [4] = '{8'h01, 8'h02, 8'h03, 8'h07};
  int         sn [4] = '{1, 1, 2, 3};
  int         sc [4] = '{0, 0, 2, 1};
  logic [7:0] sr [4] = '{8'h01, 8'h02, 8'h03, 8'h05};

  adf_feature_regs u_dut (.clk(clk), .rstn(rstn), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid),
    .chanSelect(chanSelect), .syncPin(syncPin), .outEnPin(outEnPin),
    .encodeRateLow(encodeRateLow), .miscCtrl(miscCtrl), .iqCfg(iqCfg),
    .orPinEnable(orPinEnable), .chanAssign(chanAssign));
  adf_reg_host u_host (.clk(clk), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid));

  // Free running 100 MHz clock.
  always #5 clk = ~clk;

  // Counts divider pulses so a test can tell how many got through.
  always @(posedge clk) begin
    if (miscCtrl.divSyncPulse === 1'b1) syncCount++;
  end

  // Compares one value and reports a mismatch at once.
  task chk(input logic [82:0] got, input logic [82:0] exp);
    cmpCount++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // Reads a register and checks both the valid flag and the byte.
  task rdchk(input logic [12:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    u_host.rd(a, d, v);
    chk({v, d}, {1'b1, e});
  endtask : rdchk

  // Lets derived outputs and pin synchronisers catch up.
  task settle;
    repeat (6) @(posedge clk);
    #1;
  endtask : settle

  // Gives the sync pin n rising edges, each held long enough to be seen.
  task pin(input int n);
    repeat (n) begin
      @(posedge clk);
      #1 syncPin = 1'b1;
      repeat (6) @(posedge clk);
      #1 syncPin = 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask : pin

  // Prints the verdict and ends the run.
  task results;
    if (failCount == 0 && cmpCount > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #300000;
    failCount++;
    results();
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    chanSelect = 2'b01;
    syncPin = 1'b0;
    outEnPin = 1'b1;
    encodeRateLow = 1'b1;
    repeat (8) @(posedge clk);
    #1 rstn = 1'b1;
    @(posedge clk);
    #1;
    chk(iqCfg, {12'h0, 5'h2, 5'h2, 5'h2, 56'h0});
    for (int i = 0; i < 17; i++) rdchk(al[i], rv[i]);
    for (int i = 0; i < 17; i++) u_host.wr(al[i], 8'hFF);
    for (int i = 0; i < 17; i++) rdchk(al[i], mk[i]);
    settle();
    chk(iqCfg, {12'hFF8, 15'h7FFF, 15'h7FFF, 13'h1FFF,
      14'h3FFF, 14'h3FFF});
    // Gain frozen while all terms enabled; new initial values.
    u_host.wr(adf_pkg::A_IQ_CTRL, 8'h0F);
    u_host.wr(adf_pkg::A_GAIN_LO, 8'h34);
    u_host.wr(adf_pkg::A_GAIN_HI, 8'h92);
    u_host.wr(adf_pkg::A_PHASE_LO, 8'h56);
    settle();
    chk(iqCfg.estimate, 3'b110);
    chk(iqCfg.initGain, 15'h1234);
    chk(iqCfg.initPhase, 13'h1F56);
    // Oscillator, output enable pin and pull-down combinations.
    for (int i = 0; i < 6; i++) begin
      encodeRateLow = rl[i];
      u_host.wr(adf_pkg::A_USER2, uw[i]);
      settle();
      chk(miscCtrl[2:0], ue[i]);
    end
    // Pin low with its function on: outputs stay on.
    outEnPin = 1'b0;
    u_host.wr(adf_pkg::A_USER2, 8'h80);
    settle();
    chk(miscCtrl.outputsOff, 1'b0);
    // Sync gating, continuous mode and one-shot mode.
    for (int i = 0; i < 4; i++) begin
      u_host.wr(adf_pkg::A_SYNC, sw[i]);
      syncCount = 0;
      pin(sn[i]);
      chk(syncCount, sc[i]);
      rdchk(adf_pkg::A_SYNC, sr[i]);
    end
    // Per-channel overrange enable and output assignment.
    u_host.wr(adf_pkg::A_OR_PIN, 8'h00);
    settle();
    chk(orPinEnable, 2'b10);
    chanSelect = 2'b10;
    rdchk(adf_pkg::A_OR_PIN, 8'h01);
    rdchk(adf_pkg::A_OUT_ASSGN, 8'h01);
    u_host.wr(adf_pkg::A_OUT_ASSGN, 8'h00);
    settle();
    chk(chanAssign, 2'b00);
    chanSelect = 2'b01;
    u_host.wr(adf_pkg::A_OUT_ASSGN, 8'h01);
    settle();
    chk(chanAssign, 2'b01);
    results();
  end
endmodule : adf_feature_regs_tb
